// file: core/tbpf_pkg.sv
// shared constants, types and step functions for both ends of the proximity block link
// assumes one core clock per end; the link clock is produced by the reader end
package tbpf_pkg;

  // core clock and link rates
  localparam int          CORE_KHZ       = 125000;
  localparam int          RATE_LO_KBPS   = 106;
  localparam int          RATE_HI_KBPS   = 212;
  localparam int          SUBCARRIER_KHZ = 848;
  localparam logic [9:0]  HALF_LO        = 10'(CORE_KHZ / (2 * RATE_LO_KBPS));
  localparam logic [9:0]  HALF_HI        = 10'(CORE_KHZ / (2 * RATE_HI_KBPS));
  localparam logic [6:0]  SUB_HALF       = 7'(CORE_KHZ / (2 * SUBCARRIER_KHZ));

  // framing: counts are in bit times
  localparam logic [3:0]  SOF_ZEROS      = 4'hA;
  localparam logic [3:0]  SOF_LEN        = 4'hC;
  localparam logic [11:0] SOF_PAT        = 12'hC00;
  localparam logic [3:0]  CHAR_LEN       = 4'hA;
  localparam logic [3:0]  EOF_LEN        = 4'hA;

  // sizes in bytes
  localparam logic [8:0]  MAX_FIELD      = 9'h100;
  localparam logic [8:0]  MAX_INF        = 9'h0FD;
  localparam logic [8:0]  LEN_OVH        = 9'h003;
  localparam logic [8:0]  CHAIN_MIN      = 9'h040;

  // control byte coding
  localparam logic [7:0]  PCB_I          = 8'h02;
  localparam logic [7:0]  I_MASK         = 8'hE2;
  localparam logic [7:0]  PCB_R          = 8'hA2;
  localparam logic [7:0]  R_MASK         = 8'hE6;
  localparam logic [7:0]  PCB_DESEL      = 8'hC2;
  localparam logic [7:0]  PCB_ADDR_MASK  = 8'h0C;
  localparam int          BIT_CHAIN      = 4;
  localparam int          BIT_NAK        = 4;
  localparam int          BIT_BN         = 0;

  // check code
  localparam logic [15:0] CRC_INIT       = 16'hFFFF;
  localparam logic [15:0] CRC_POLY       = 16'h8408;
  localparam logic [15:0] CRC_RESIDUE    = 16'hF0B8;

  typedef enum logic [1:0] {
    TX_IDLE = 2'b00,
    TX_SOF  = 2'b01,
    TX_DATA = 2'b10,
    TX_EOF  = 2'b11
  } tbpf_tx_ph_e;

  typedef enum logic [1:0] {
    RX_HUNT  = 2'b00,
    RX_START = 2'b01,
    RX_DATA  = 2'b10,
    RX_STOP  = 2'b11
  } tbpf_rx_ph_e;

  typedef struct packed {
    tbpf_tx_ph_e ph;
    logic [11:0] sh;
    logic [3:0]  cnt;
    logic        line;
    logic        take;
  } tbpf_tx_s;

  typedef struct packed {
    tbpf_rx_ph_e st;
    logic [3:0]  zc;
    logic [7:0]  sh;
    logic [2:0]  bc;
    logic        byte_ev;
    logic        eof_ev;
    logic        err_ev;
  } tbpf_rx_s;

  function automatic logic [15:0] crc_b(input logic [15:0] c, input logic [7:0] b);
    logic [15:0] r;
    r = c ^ {8'h00, b};
    for (int i = 0; i < 8; i++) begin
      r = r[0] ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
    end
    return r;
  endfunction

  function automatic logic is_iblk(input logic [7:0] p);
    return (p & I_MASK) == PCB_I;
  endfunction

  function automatic logic is_rblk(input logic [7:0] p);
    return (p & R_MASK) == PCB_R;
  endfunction

  // one bit time of the sender: start of frame, characters lsb first, end of frame
  function automatic tbpf_tx_s tx_step(input tbpf_tx_s s, input logic more, input logic [7:0] b);
    tbpf_tx_s    n;
    logic [11:0] ld;
    logic [3:0]  lc;
    logic        go;
    n      = s;
    n.take = 1'b0;
    ld     = s.sh;
    lc     = s.cnt;
    go     = 1'b1;
    if (s.cnt == 4'h0) begin
      case (s.ph)
        TX_SOF: begin
          ld   = SOF_PAT;
          lc   = SOF_LEN;
          n.ph = TX_DATA;
        end
        TX_DATA: begin
          if (more) begin
            ld     = {3'b001, b, 1'b0};
            lc     = CHAR_LEN;
            n.take = 1'b1;
          end else begin
            ld   = 12'h000;
            lc   = EOF_LEN;
            n.ph = TX_EOF;
          end
        end
        TX_EOF: begin
          go   = 1'b0;
          n.ph = TX_IDLE;
        end
        default: go = 1'b0;
      endcase
    end
    if (go) begin
      n.line = ld[0];
      n.sh   = ld >> 1;
      n.cnt  = lc - 4'h1;
    end else begin
      n.line = 1'b1;
      n.cnt  = 4'h0;
    end
    return n;
  endfunction

  // one bit time of the receiver; an all-zero character with a low stop bit is the end of frame
  function automatic tbpf_rx_s rx_step(input tbpf_rx_s s, input logic b);
    tbpf_rx_s n;
    n         = s;
    n.byte_ev = 1'b0;
    n.eof_ev  = 1'b0;
    n.err_ev  = 1'b0;
    case (s.st)
      RX_HUNT: begin
        if (!b) begin
          if (s.zc != 4'hF) n.zc = s.zc + 4'h1;
        end else begin
          if (s.zc >= SOF_ZEROS) n.st = RX_START;
          n.zc = 4'h0;
        end
      end
      RX_START: begin
        if (!b) begin
          n.st = RX_DATA;
          n.bc = 3'h0;
        end
      end
      RX_DATA: begin
        n.sh = {b, s.sh[7:1]};
        n.bc = s.bc + 3'h1;
        if (s.bc == 3'h7) n.st = RX_STOP;
      end
      RX_STOP: begin
        if (b) begin
          n.byte_ev = 1'b1;
          n.st      = RX_START;
        end else begin
          n.eof_ev = 1'b1;
          n.err_ev = (s.sh != 8'h00);
          n.st     = RX_HUNT;
          n.zc     = 4'h0;
        end
      end
      default: n.st = RX_HUNT;
    endcase
    return n;
  endfunction

endpackage

// file: core/tbpf_link_if.sv
// the air link between reader and card, reduced to logic levels
// assumes the bench joins both ends; the reader makes the link clock
`timescale 1ns/1ps
`default_nettype none
interface tbpf_link_if;
  logic link_clk;
  logic r2c;
  logic bpsk;
  logic sub;
  modport reader (output link_clk, output r2c, input bpsk, input sub);
  modport card (input link_clk, input r2c, output bpsk, output sub);
endinterface
`default_nettype wire

// file: core/tbpf_reader_end.sv
// reader end: makes the link clock, sends one block per request, reports answer bytes
// assumes the user keeps command bytes valid while a block is being sent
`timescale 1ns/1ps
`default_nettype none
module tbpf_reader_end (
  // clock and reset
  input  wire logic       core_clk_i,
  input  wire logic       rst_i,
  // link
  tbpf_link_if.reader     lnk,
  // command side
  input  wire logic       rate_hi_i,
  input  wire logic       send_i,
  input  wire logic [7:0] pcb_i,
  input  wire logic       cmd_valid_i,
  input  wire logic [7:0] cmd_data_i,
  input  wire logic       cmd_last_i,
  output logic            cmd_ready_o,
  output logic            busy_o,
  output logic            chain_short_o,
  // answer side
  output logic            rsp_valid_o,
  output logic [7:0]      rsp_data_o,
  output logic            rsp_end_o,
  output logic            rsp_ok_o
);

  typedef enum logic [2:0] {
    RP_PCB  = 3'b000,
    RP_DATA = 3'b001,
    RP_CRC0 = 3'b010,
    RP_CRC1 = 3'b011,
    RP_DONE = 3'b100
  } tbpf_rd_ph_e;

  typedef struct packed {
    logic              lk;
    logic [9:0]        dc;
    logic              b1;
    logic              b2;
    logic              s1;
    logic              s2;
    tbpf_rd_ph_e       rp;
    logic [7:0]        pcb;
    logic [8:0]        cnt;
    logic [15:0]       tcrc;
    logic [15:0]       rcrc;
    tbpf_pkg::tbpf_rx_s rx;
    tbpf_pkg::tbpf_tx_s tx;
    logic              short_ev;
    logic              rend;
    logic              ok;
  } tbpf_reader_s;

  tbpf_reader_s s_ff;
  tbpf_reader_s nxt_s;
  tbpf_rd_ph_e  eff;
  logic [9:0]   half;
  logic         fall;
  logic [7:0]   tbyte;
  logic         take_data;

  always_comb begin
    nxt_s            = s_ff;
    nxt_s.short_ev   = 1'b0;
    nxt_s.rend       = 1'b0;
    nxt_s.rx.byte_ev = 1'b0;
    nxt_s.rx.eof_ev  = 1'b0;
    nxt_s.rx.err_ev  = 1'b0;
    nxt_s.tx.take    = 1'b0;
    nxt_s.b1         = lnk.bpsk;
    nxt_s.b2         = s_ff.b1;
    nxt_s.s1         = lnk.sub;
    nxt_s.s2         = s_ff.s1;
    take_data        = 1'b0;
    fall             = 1'b0;
    half             = rate_hi_i ? tbpf_pkg::HALF_HI : tbpf_pkg::HALF_LO;
    // link clock divider, one bit per period
    if (s_ff.dc >= half - 10'h001) begin
      nxt_s.dc = 10'h000;
      nxt_s.lk = ~s_ff.lk;
      fall     = s_ff.lk;
    end else begin
      nxt_s.dc = s_ff.dc + 10'h001;
    end
    // a missing command byte ends the information field
    eff = (s_ff.rp == RP_DATA && !cmd_valid_i) ? RP_CRC0 : s_ff.rp;
    case (eff)
      RP_PCB:  tbyte = s_ff.pcb;
      RP_DATA: tbyte = cmd_data_i;
      RP_CRC0: tbyte = ~s_ff.tcrc[7:0];
      RP_CRC1: tbyte = ~s_ff.tcrc[15:8];
      default: tbyte = 8'h00;
    endcase
    if (send_i && s_ff.tx.ph == tbpf_pkg::TX_IDLE) begin
      // R5: no address fields
      nxt_s.pcb    = pcb_i & ~tbpf_pkg::PCB_ADDR_MASK;
      nxt_s.tx.ph  = tbpf_pkg::TX_SOF;
      nxt_s.tx.cnt = 4'h0;
      nxt_s.rp     = RP_PCB;
      nxt_s.tcrc   = tbpf_pkg::CRC_INIT;
      nxt_s.cnt    = 9'h000;
    end else if (fall) begin
      // R2 R3: character and frame sending
      nxt_s.tx = tbpf_pkg::tx_step(s_ff.tx, eff != RP_DONE, tbyte);
      if (nxt_s.tx.take) begin
        // R9: running check code
        if (eff == RP_PCB || eff == RP_DATA) nxt_s.tcrc = tbpf_pkg::crc_b(s_ff.tcrc, tbyte);
        case (eff)
          // R11: R and S blocks carry no data
          RP_PCB:  nxt_s.rp = tbpf_pkg::is_iblk(s_ff.pcb) ? RP_DATA : RP_CRC0;
          RP_DATA: begin
            take_data = 1'b1;
            nxt_s.cnt = s_ff.cnt + 9'h001;
            if (cmd_last_i || s_ff.cnt + 9'h001 == tbpf_pkg::MAX_INF) begin
              nxt_s.rp = RP_CRC0;
              // R16: flag short chained pieces
              nxt_s.short_ev = s_ff.pcb[tbpf_pkg::BIT_CHAIN] && (s_ff.cnt + 9'h001 < tbpf_pkg::CHAIN_MIN);
            end
          end
          RP_CRC0: nxt_s.rp = RP_CRC1;
          default: nxt_s.rp = RP_DONE;
        endcase
      end
    end
    // R1: answer recovered from subcarrier phase
    if (s_ff.rx.st == tbpf_pkg::RX_HUNT) nxt_s.rcrc = tbpf_pkg::CRC_INIT;
    if (fall) begin
      nxt_s.rx = tbpf_pkg::rx_step(s_ff.rx, s_ff.b2 ^ s_ff.s2);
      if (nxt_s.rx.byte_ev) nxt_s.rcrc = tbpf_pkg::crc_b(s_ff.rcrc, nxt_s.rx.sh);
      if (nxt_s.rx.eof_ev) begin
        nxt_s.rend = 1'b1;
        nxt_s.ok   = !nxt_s.rx.err_ev && s_ff.rcrc == tbpf_pkg::CRC_RESIDUE;
      end
    end
    if (rst_i) begin
      nxt_s         = '0;
      nxt_s.rp      = RP_DONE;
      nxt_s.tx.line = 1'b1;
    end
  end

  always_ff @(posedge core_clk_i) begin
    s_ff <= nxt_s;
  end

  assign lnk.link_clk  = s_ff.lk;
  assign lnk.r2c       = s_ff.tx.line;
  assign cmd_ready_o   = take_data;
  assign busy_o        = (s_ff.tx.ph != tbpf_pkg::TX_IDLE);
  assign chain_short_o = s_ff.short_ev;
  assign rsp_valid_o   = s_ff.rx.byte_ev;
  assign rsp_data_o    = s_ff.rx.sh;
  assign rsp_end_o     = s_ff.rend;
  assign rsp_ok_o      = s_ff.ok;

endmodule
`default_nettype wire

// file: core/tbpf_card_end.sv
// card end: decodes reader blocks, hands data to the user, answers with blocks
// assumes the reader end makes the link clock and changes its data on the falling edge
//
// What this block does
// R1: answer by subcarrier phase, decode level-coded commands
// R2: characters lsb first, start, eight data, stop
// R3: frame is start delimiter, data, end delimiter
// R4: data field never longer than 256 bytes
// R5: reader sends no card or node address
// R6: card never adds or uses address fields
// R7: first data byte is the control byte
// R8: information field follows the control byte
// R9: two-byte check code closes every block
// R10: three block types; I-block carries data
// R11: R-block is acknowledge or refusal, no data
// R12: R-block reply refers to last received block
// R13: S-block is wait extension or deselect
// R14: card never asks for wait extension
// R15: deselect is answered, then card goes quiet
// R16: chaining supported, pieces at least 64 bytes
// R17: card makes and reads acknowledge and refusal
// R18: empty message needs memory preset by others
`timescale 1ns/1ps
`default_nettype none
module tbpf_card_end (
  // clock and reset
  input  wire logic       core_clk_i,
  input  wire logic       rst_i,
  // link
  tbpf_link_if.card       lnk,
  // session
  input  wire logic       activate_i,
  output logic            deselected_o,
  output logic            rx_err_o,
  // received information
  output logic            rx_valid_o,
  output logic [7:0]      rx_data_o,
  output logic            rx_last_o,
  // response information
  input  wire logic       tx_valid_i,
  input  wire logic [7:0] tx_data_i,
  input  wire logic       tx_last_i,
  input  wire logic       tx_chain_i,
  output logic            tx_ready_o
);

  typedef enum logic [2:0] {
    C_RX    = 3'b000,
    C_DLV   = 3'b001,
    C_FILL  = 3'b010,
    C_SEND  = 3'b011,
    C_DESEL = 3'b100
  } tbpf_card_st_e;

  typedef struct packed {
    logic                 lk1;
    logic                 lk2;
    logic                 lk3;
    logic                 d1;
    logic                 d2;
    logic                 sc;
    logic [6:0]           scc;
    logic                 bp;
    tbpf_card_st_e        st;
    tbpf_pkg::tbpf_rx_s   rx;
    tbpf_pkg::tbpf_tx_s   tx;
    logic                 txon;
    logic [15:0]          crc;
    logic [8:0]           cnt;
    logic                 ovf;
    logic [7:0]           pcb;
    logic                 bn;
    logic                 rx_chain;
    logic                 tx_chain;
    logic                 desel_pend;
    logic                 desel;
    logic [8:0]           ti;
    logic [7:0]           tpcb;
    logic [8:0]           tlen;
    logic [7:0]           ipcb;
    logic [8:0]           ilen;
    logic                 rxv;
    logic                 rxl;
    logic [7:0]           rxd;
    logic                 err;
    logic [255:0][7:0]    mem;
  } tbpf_card_s;

  tbpf_card_s s_ff;
  tbpf_card_s nxt_s;
  logic       rise;
  logic [8:0] len;
  logic [8:0] tim1;
  logic       good;
  logic       chain_ok;
  logic [7:0] tbyte;

  always_comb begin
    nxt_s            = s_ff;
    nxt_s.rxv        = 1'b0;
    nxt_s.rxl        = 1'b0;
    nxt_s.err        = 1'b0;
    nxt_s.rx.byte_ev = 1'b0;
    nxt_s.rx.eof_ev  = 1'b0;
    nxt_s.rx.err_ev  = 1'b0;
    nxt_s.tx.take    = 1'b0;
    nxt_s.lk1        = lnk.link_clk;
    nxt_s.lk2        = s_ff.lk1;
    nxt_s.lk3        = s_ff.lk2;
    nxt_s.d1         = lnk.r2c;
    nxt_s.d2         = s_ff.d1;
    rise             = s_ff.lk2 & ~s_ff.lk3;
    len              = s_ff.cnt - tbpf_pkg::LEN_OVH;
    tim1             = s_ff.ti - 9'h001;
    good             = 1'b0;
    chain_ok         = 1'b0;
    // R1: subcarrier for the answer
    if (s_ff.scc == tbpf_pkg::SUB_HALF - 7'h01) begin
      nxt_s.scc = 7'h00;
      nxt_s.sc  = ~s_ff.sc;
    end else begin
      nxt_s.scc = s_ff.scc + 7'h01;
    end
    // R7 R8 R9: control byte, information, check code
    if (s_ff.ti == 9'h000) begin
      tbyte = s_ff.tpcb;
    end else if (s_ff.ti <= s_ff.tlen) begin
      tbyte = s_ff.mem[tim1[7:0]];
    end else if (s_ff.ti == s_ff.tlen + 9'h001) begin
      tbyte = ~s_ff.crc[7:0];
    end else begin
      tbyte = ~s_ff.crc[15:8];
    end
    case (s_ff.st)
      C_RX: begin
        if (s_ff.rx.st == tbpf_pkg::RX_HUNT) begin
          nxt_s.cnt = 9'h000;
          nxt_s.ovf = 1'b0;
          nxt_s.crc = tbpf_pkg::CRC_INIT;
        end
        if (rise) begin
          // R1 R2 R3: level-coded characters within a frame
          nxt_s.rx = tbpf_pkg::rx_step(s_ff.rx, s_ff.d2);
          if (nxt_s.rx.byte_ev) begin
            nxt_s.crc = tbpf_pkg::crc_b(s_ff.crc, nxt_s.rx.sh);
            if (s_ff.cnt == 9'h000) nxt_s.pcb = nxt_s.rx.sh;
            // R4: longer frames marked bad
            if (s_ff.cnt == tbpf_pkg::MAX_FIELD) begin
              nxt_s.ovf = 1'b1;
            end else begin
              nxt_s.cnt = s_ff.cnt + 9'h001;
              if (s_ff.cnt != 9'h000 && tbpf_pkg::is_iblk(s_ff.pcb)) nxt_s.mem[8'(s_ff.cnt - 9'h001)] = nxt_s.rx.sh;
            end
          end
          if (nxt_s.rx.eof_ev) begin
            good     = !nxt_s.rx.err_ev && !s_ff.ovf && s_ff.cnt >= tbpf_pkg::LEN_OVH
                       && s_ff.crc == tbpf_pkg::CRC_RESIDUE;
            // R16: short chained pieces refused
            chain_ok = !s_ff.pcb[tbpf_pkg::BIT_CHAIN] || len >= tbpf_pkg::CHAIN_MIN;
            nxt_s.ti = 9'h000;
            // R10 R5: I-block with no address fields
            if (good && tbpf_pkg::is_iblk(s_ff.pcb) && (s_ff.pcb & tbpf_pkg::PCB_ADDR_MASK) == 8'h00 && chain_ok) begin
              nxt_s.bn       = ~s_ff.bn;
              nxt_s.rx_chain = s_ff.pcb[tbpf_pkg::BIT_CHAIN];
              nxt_s.tlen     = len;
              nxt_s.st       = C_DLV;
            // R17: acknowledge or refusal with matching block number repeats last I-block
            end else if (good && tbpf_pkg::is_rblk(s_ff.pcb) && s_ff.pcb[tbpf_pkg::BIT_BN] == s_ff.bn) begin
              nxt_s.tpcb = s_ff.ipcb;
              nxt_s.tlen = s_ff.ilen;
              nxt_s.st   = C_SEND;
            // R17: acknowledge of a chained answer asks for the next piece
            end else if (good && tbpf_pkg::is_rblk(s_ff.pcb) && !s_ff.pcb[tbpf_pkg::BIT_NAK] && s_ff.tx_chain) begin
              nxt_s.bn       = ~s_ff.bn;
              nxt_s.tx_chain = 1'b0;
              nxt_s.st       = C_FILL;
            // R13 R15: deselect answered in kind
            end else if (good && s_ff.pcb == tbpf_pkg::PCB_DESEL) begin
              nxt_s.tpcb       = tbpf_pkg::PCB_DESEL;
              nxt_s.tlen       = 9'h000;
              nxt_s.desel_pend = 1'b1;
              nxt_s.st         = C_SEND;
            end else begin
              // R14 R12: wait extension and bad blocks get an R-block
              nxt_s.err  = 1'b1;
              nxt_s.tpcb = tbpf_pkg::PCB_R | {3'b000, ~s_ff.rx_chain, 3'b000, s_ff.bn};
              nxt_s.tlen = 9'h000;
              nxt_s.st   = C_SEND;
            end
          end
        end
      end
      C_DLV: begin
        if (s_ff.ti == s_ff.tlen) begin
          nxt_s.ti = 9'h000;
          if (s_ff.rx_chain) begin
            // R16 R12: chained piece acknowledged with own number
            nxt_s.tpcb = tbpf_pkg::PCB_R | {7'h00, s_ff.bn};
            nxt_s.tlen = 9'h000;
            nxt_s.st   = C_SEND;
          end else begin
            nxt_s.st = C_FILL;
          end
        end else begin
          nxt_s.rxv = 1'b1;
          nxt_s.rxd = s_ff.mem[s_ff.ti[7:0]];
          nxt_s.rxl = (s_ff.ti == s_ff.tlen - 9'h001) && !s_ff.rx_chain;
          nxt_s.ti  = s_ff.ti + 9'h001;
        end
      end
      C_FILL: begin
        if (tx_valid_i) begin
          nxt_s.mem[s_ff.ti[7:0]] = tx_data_i;
          nxt_s.ti                = s_ff.ti + 9'h001;
          if (tx_last_i || s_ff.ti + 9'h001 == tbpf_pkg::MAX_INF) begin
            // R16: chain only pieces of enough length
            chain_ok       = tx_chain_i && (s_ff.ti + 9'h001 >= tbpf_pkg::CHAIN_MIN);
            nxt_s.ipcb     = tbpf_pkg::PCB_I | {3'b000, chain_ok, 3'b000, s_ff.bn};
            nxt_s.ilen     = s_ff.ti + 9'h001;
            nxt_s.tx_chain = chain_ok;
            nxt_s.tpcb     = tbpf_pkg::PCB_I | {3'b000, chain_ok, 3'b000, s_ff.bn};
            nxt_s.tlen     = s_ff.ti + 9'h001;
            nxt_s.ti       = 9'h000;
            nxt_s.st       = C_SEND;
          end
        end
      end
      C_SEND: begin
        if (!s_ff.txon) begin
          nxt_s.txon   = 1'b1;
          nxt_s.tx.ph  = tbpf_pkg::TX_SOF;
          nxt_s.tx.cnt = 4'h0;
          nxt_s.crc    = tbpf_pkg::CRC_INIT;
          nxt_s.ti     = 9'h000;
        end else if (s_ff.tx.ph == tbpf_pkg::TX_IDLE) begin
          nxt_s.txon       = 1'b0;
          nxt_s.desel_pend = 1'b0;
          nxt_s.rx         = '0;
          nxt_s.rx_chain   = s_ff.rx_chain && !s_ff.desel_pend;
          nxt_s.desel      = s_ff.desel_pend;
          nxt_s.st         = s_ff.desel_pend ? C_DESEL : C_RX;
        end else if (rise) begin
          // R6 R3: own blocks carry no address fields
          nxt_s.tx = tbpf_pkg::tx_step(s_ff.tx, s_ff.ti < s_ff.tlen + tbpf_pkg::LEN_OVH, tbyte);
          if (nxt_s.tx.take) begin
            if (s_ff.ti <= s_ff.tlen) nxt_s.crc = tbpf_pkg::crc_b(s_ff.crc, tbyte);
            nxt_s.ti = s_ff.ti + 9'h001;
          end
        end
      end
      C_DESEL: begin
        // R15: quiet until activated again
        if (activate_i) begin
          nxt_s.desel    = 1'b0;
          nxt_s.bn       = 1'b1;
          nxt_s.rx_chain = 1'b0;
          nxt_s.tx_chain = 1'b0;
          nxt_s.rx       = '0;
          nxt_s.st       = C_RX;
        end
      end
      default: nxt_s.st = C_RX;
    endcase
    // R1: phase flips carry the answer bits
    nxt_s.bp = nxt_s.tx.line ^ nxt_s.sc;
    if (rst_i) begin
      nxt_s         = '0;
      nxt_s.bn      = 1'b1;
      nxt_s.ipcb    = tbpf_pkg::PCB_I | 8'h01;
      nxt_s.tx.line = 1'b1;
      nxt_s.bp      = 1'b1;
    end
  end

  always_ff @(posedge core_clk_i) begin
    s_ff <= nxt_s;
  end

  assign lnk.bpsk     = s_ff.bp;
  assign lnk.sub      = s_ff.sc;
  assign deselected_o = s_ff.desel;
  assign rx_err_o     = s_ff.err;
  assign rx_valid_o   = s_ff.rxv;
  assign rx_data_o    = s_ff.rxd;
  assign rx_last_o    = s_ff.rxl;
  assign tx_ready_o   = (s_ff.st == C_FILL);

endmodule
`default_nettype wire

// file: verification/tbpf_link_properties.sv
// checker for the reader-card link signals
// assumes both ends run on core_clk_i and share rst_i
`timescale 1ns/1ps
`default_nettype none
module tbpf_link_properties (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic rst_i,
  // link
  input wire logic link_clk,
  input wire logic r2c,
  input wire logic bpsk,
  input wire logic sub
);
  logic [9:0] lk_n;
  logic [6:0] sb_n;
  logic [3:0] fl_n;
  logic [3:0] rs_n;
  // previous link_clk, sub, r2c, bpsk, then seen-toggle flags
  logic [5:0] q;
  wire logic  rise = link_clk & ~q[0];
  wire logic  fall = ~link_clk & q[0];
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (rst_i);
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      {lk_n, sb_n, fl_n, rs_n} <= '0;
      q <= 6'h0C;
    end else begin
      q    <= {q[5:4] | {sub ^ q[1], link_clk ^ q[0]}, bpsk, r2c, sub, link_clk};
      lk_n <= (link_clk ^ q[0]) ? 10'h000 : lk_n + 10'h001;
      sb_n <= (sub ^ q[1]) ? 7'h00 : sb_n + {6'h00, ~&sb_n};
      fl_n <= fall ? 4'h0 : fl_n + {3'h0, ~&fl_n};
      rs_n <= rise ? 4'h0 : rs_n + {3'h0, ~&rs_n};
    end
  end
  chk_reset_idle: assert property ($fell(rst_i) |-> !link_clk && r2c && bpsk && !sub)
    else $error("link not idle after reset");
  chk_link_half: assert property (q[4] && link_clk != q[0] |-> lk_n == 10'h125 || lk_n == 10'h24C)
    else $error("link half period wrong");
  chk_link_runs: assert property (lk_n <= 10'h24C)
    else $error("link clock stalled");
  chk_sub_rate: assert property (q[5] && sub != q[1] |-> sb_n >= 7'h48)
    else $error("subcarrier too fast");
  chk_r2c_at_fall: assert property (r2c != q[2] |-> fall || fl_n <= 4'h2)
    else $error("reader bit off the falling edge");
  chk_r2c_holds: assert property (r2c != q[2] |=> $stable(r2c) [*8])
    else $error("reader bit too short");
  chk_quiet_send: assert property (!r2c && sub == q[1] && bpsk == q[3] |-> bpsk ^ sub)
    else $error("card talks over the reader");
  chk_ans_at_rise: assert property (bpsk != q[3] |-> sub != q[1] || sb_n == 7'h00 || rise || rs_n <= 4'hA)
    else $error("answer bit off the rising edge");
  cov_frame: cover property (!r2c && q[2]);
  cov_answer: cover property (r2c && !(bpsk ^ sub));
  cov_rise: cover property (q[4] && rise);
endmodule
`default_nettype wire

// file: verification/test_typeb_block_protocol_framer.sv
// bench: reader and card joined by the link; one block exchange, then deselect
// assumes one shared core clock and reset for both ends
`timescale 1ns/1ps
`default_nettype none
module test_typeb_block_protocol_framer;
  logic        core_clk_i = 1'b0, rst_i = 1'b1, rate_hi_i = 1'b1, cmd_last_i = 1'b1, tx_last_i = 1'b1;
  logic        tx_chain_i = 1'b0, send_i = 1'b0, cmd_valid_i = 1'b0, activate_i = 1'b0, tx_valid_i = 1'b0;
  logic [7:0]  pcb_i = 8'h00, cmd_data_i = 8'h00, tx_data_i = 8'h00, rsp_data_o, rx_data_o;
  logic        cmd_ready_o, busy_o, chain_short_o, rsp_valid_o, rsp_end_o, rsp_ok_o;
  logic        deselected_o, rx_err_o, rx_valid_o, rx_last_o, tx_ready_o;
  logic [31:0] rnd = 32'h00011492;
  logic [7:0]  exp_rx[$], exp_rsp[$];
  int          fail_count = 0, total_checks = 0, ends = 0, e0 = 0;
  tbpf_link_if lnk ();
  tbpf_reader_end i_tbpf_reader_end (.*);
  tbpf_card_end i_tbpf_card_end (.*);
  tbpf_link_properties i_tbpf_link_properties (.core_clk_i(core_clk_i), .rst_i(rst_i),
    .link_clk(lnk.link_clk), .r2c(lnk.r2c), .bpsk(lnk.bpsk), .sub(lnk.sub));
  always #4 core_clk_i = ~core_clk_i;
  function automatic logic [15:0] crc(input logic [15:0] c, input logic [7:0] b);
    c = c ^ {8'h00, b};
    for (int i = 0; i < 8; i++) c = c[0] ? (c >> 1) ^ tbpf_pkg::CRC_POLY : c >> 1;
    return c;
  endfunction
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic chk8(input logic [7:0] e, input logic [7:0] a);
    total_checks++;
    if (a !== e) begin
      fail_count++;
      $display("[ERR] %0t exp %h got %h", $time, e, a);
    end
  endtask
  task automatic wrap_up;
    $display("checks %0d fails %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // 0 byte taken, 1 card collecting, 2 deselected, 3 answer ended
  task automatic wait_hi(input int w);
    int k;
    k = 0;
    do begin
      @(negedge core_clk_i);
      k++;
    end while ((w == 0 ? cmd_ready_o : w == 1 ? tx_ready_o : w == 2 ? deselected_o : ends > e0) !== 1'b1
               && k < 99999);
    if (k >= 99999) fail_count++;
  endtask
  // one block to the card and its answer back, expectations noted first
  task automatic blk(input logic [7:0] p, input logic [7:0] rp, input logic inf);
    logic [15:0] c;
    logic [7:0]  d;
    logic [7:0]  rd;
    rnd = lfsr(rnd);
    d = rnd[7:0];
    rd = rnd[15:8];
    c = crc(tbpf_pkg::CRC_INIT, rp);
    exp_rsp.push_back(rp);
    if (inf) begin
      exp_rx.push_back(d);
      exp_rsp.push_back(rd);
      c = crc(c, rd);
    end
    exp_rsp.push_back(~c[7:0]);
    exp_rsp.push_back(~c[15:8]);
    e0 = ends;
    @(posedge core_clk_i);
    send_i <= 1'b1;
    pcb_i <= p;
    cmd_valid_i <= inf;
    cmd_data_i <= d;
    @(posedge core_clk_i);
    send_i <= 1'b0;
    @(negedge core_clk_i);
    chk8(8'h01, {7'h00, busy_o});
    if (inf) begin
      wait_hi(0);
      @(posedge core_clk_i);
      cmd_valid_i <= 1'b0;
      wait_hi(1);
      @(posedge core_clk_i);
      tx_valid_i <= 1'b1;
      tx_data_i <= rd;
      @(posedge core_clk_i);
      tx_valid_i <= 1'b0;
    end
    wait_hi(3);
    chk8(8'h00, 8'(exp_rsp.size() + exp_rx.size()));
    chk8(8'h00, {7'h00, busy_o});
  endtask
  always @(negedge core_clk_i) begin
    if (rx_valid_o === 1'b1) begin
      chk8(exp_rx.pop_front(), rx_data_o);
      chk8(8'h01, {7'h00, rx_last_o});
    end
    if (rsp_valid_o === 1'b1) chk8(exp_rsp.pop_front(), rsp_data_o);
    if (rsp_end_o === 1'b1) begin
      chk8(8'h01, {7'h00, rsp_ok_o});
      ends++;
    end
    if (rx_err_o !== 1'b0 || chain_short_o !== 1'b0) chk8(8'h00, 8'h01);
  end
  initial begin
    repeat (6) @(posedge core_clk_i);
    rst_i <= 1'b0;
    // address bits in the control byte are cleared before sending
    blk(8'h0A, 8'h02, 1'b1);
    $display("test block exchange done");
    blk(8'hC2, 8'hC2, 1'b0);
    wait_hi(2);
    chk8(8'h01, {7'h00, deselected_o});
    @(posedge core_clk_i);
    activate_i <= 1'b1;
    @(posedge core_clk_i);
    activate_i <= 1'b0;
    repeat (3) @(negedge core_clk_i);
    chk8(8'h00, {7'h00, deselected_o});
    $display("test deselect done");
    wrap_up;
  end
  initial begin
    repeat (250000) @(posedge core_clk_i);
    fail_count++;
    wrap_up;
  end
endmodule
`default_nettype wire
